/* rtl/mdlc_defines.vh */
`ifndef MDLC_DEFINES_VH
`define MDLC_DEFINES_VH

// ----------------------------------------------------------------
// Register windows and offsets
// ----------------------------------------------------------------
`define MDLC_WIN_LATE_COLL 3'h6
`define MDLC_OFF_LATE_COLL 4'h4
`define MDLC_WIN_MAC_SET 3'h3
`define MDLC_OFF_MAC_SET 4'h6
`define MDLC_OFF_STATUS 4'he

// ----------------------------------------------------------------
// Settings register layout and reset value
// ----------------------------------------------------------------
`define MDLC_MAC_SET_RESET 16'h0000
`define MDLC_MAC_SET_USED 16'h007f
`define MDLC_BIT_EXT_DEFER 0
`define MDLC_FLD_DEFER_HI 4
`define MDLC_FLD_DEFER_LO 1
`define MDLC_BIT_TWO_WAY 5
`define MDLC_BIT_BIG_FRAME 6
`define MDLC_BIT_NEED_READ 7

// ----------------------------------------------------------------
// Late collision counter
// ----------------------------------------------------------------
`define MDLC_CNT_ZERO 8'h00
`define MDLC_CNT_ONE 8'h01
`define MDLC_CNT_MID 8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MDLC_CLK_PERIOD_NS 10
`define MDLC_BIT_NS_10M 100
`define MDLC_BIT_NS_100M 10
`define MDLC_SLOT_BITS 10'd512
`define MDLC_IFS_BITS 10'd96
`define MDLC_EXTRA_STEP_BITS 10'd32
`define MDLC_EXTRA_MIN_CODE 4'h2

// ----------------------------------------------------------------
// Receive frame size limits, header through payload
// ----------------------------------------------------------------
`define MDLC_OVERSIZE_STD 13'd1515
`define MDLC_OVERSIZE_BIG 13'd4491
`define MDLC_FCS_BYTES 13'd4

`endif

/* rtl/mdlc_defer_timer.v */
`timescale 1ns/1ps
`include "mdlc_defines.vh"

module mdlc_defer_timer (
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire bitTick,
	input wire mediumBusy,
	input wire txSuccess,
	input wire extendOn,
	input wire [3:0] extraCode,
	output wire deferDone
);

// Wide enough for the longest gap, standard plus largest extra
reg [9:0] remainBits;
wire [9:0] extraBits;
wire [9:0] codeLess;
wire [19:0] extraProd;

assign codeLess = {6'h00, extraCode} - 10'd1;
assign extraProd = codeLess * `MDLC_EXTRA_STEP_BITS;
// RULE9: extra bit times
// RULE10: code ignored when off
assign extraBits = (!extendOn || extraCode < `MDLC_EXTRA_MIN_CODE) ? 10'd0 : extraProd[9:0];

// ----------------------------------------------------------------
// Gap counter, reloaded by activity, counted down while idle
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		remainBits <= 10'd0;
	end else if (ce) begin
		if (txSuccess) begin
			// RULE7: longer gap after success
			remainBits <= `MDLC_IFS_BITS + extraBits;
		end else if (mediumBusy) begin
			// RULE8: standard gap
			remainBits <= `MDLC_IFS_BITS;
		end else if (bitTick && remainBits != 10'd0) begin
			remainBits <= remainBits - 10'd1;
		end
	end
end

assign deferDone = !mediumBusy && remainBits == 10'd0;

endmodule

/* rtl/mdlc_late_counter.v */
`timescale 1ns/1ps
`include "mdlc_defines.vh"

module mdlc_late_counter (
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire countEvent,
	input wire readClear,
	output reg [7:0] count,
	output wire passedMid
);

// RULE3: crossing past midpoint
assign passedMid = countEvent && count == `MDLC_CNT_MID;

always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		count <= `MDLC_CNT_ZERO;
	end else if (ce) begin
		if (readClear && countEvent) begin
			// RULE17: event kept on clear
			count <= `MDLC_CNT_ONE;
		end else if (readClear) begin
			// RULE4: clear on read
			count <= `MDLC_CNT_ZERO;
		end else if (countEvent) begin
			// RULE2: wraps after all ones
			count <= count + `MDLC_CNT_ONE;
		end
	end
end

endmodule

/* rtl/mdlc_top.v */
// Function
// RULE1: Count each late collision on every transmit attempt, several per frame possible.
// RULE2: Late collision counter is eight bits and wraps to zero after all ones.
// RULE3: Raise statistics-update indication when the counter counts past its midpoint.
// RULE4: Reading the late collision counter returns its value, then clears it.
// RULE5: Counting happens only after the host issues the statistics-enable command.
// RULE6: The sixteen-bit settings register resets to zero, all special modes off.
// RULE7: Extended deference bit lengthens the gap after each successful transmission.
// RULE8: Without extended deference use standard gap timing, scaled at the higher rate.
// RULE9: Defer code adds nothing for 0 and 1, else (n-1)*32 bit times.
// RULE10: The defer code is ignored while extended deference is off.
// RULE11: Two-way simultaneous bit stops deferring to receive activity.
// RULE12: Two-way mode masks carrier from transmitter and halts lost-carrier counting.
// RULE13: Host issues transmitter and receiver reset after changing two-way mode.
// RULE14: Big frame bit moves the too-long limit from 1515 to 4491 bytes.
// RULE15: Compared length counts addresses and type field, but not the FCS.
// RULE16: Update indication shows at status bit 7, cleared after all counters read.
// RULE17: A late collision during a clearing read is kept, leaving count one.
// RULE18: A collision after the first 512 bit times of an attempt is late.
`timescale 1ns/1ps
`include "mdlc_defines.vh"

module mdlc_top (
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire [2:0] ioWindow,
	input wire [3:0] ioAddr,
	input wire ioRd,
	input wire ioWr,
	input wire [15:0] ioWrData,
	output reg [15:0] ioRdData,
	input wire otherStatsRead,
	input wire countingTurnOnCmd,
	input wire linkIs100,
	input wire txAttemptStart,
	input wire txActive,
	input wire txSuccess,
	input wire collisionPin,
	input wire carrierPin,
	input wire rxFrameStart,
	input wire rxByteStrobe,
	input wire rxFrameEnd,
	output wire txMayStart,
	output wire carrierToTx,
	output wire lostCarrierCountOn,
	output reg frameTooLongError,
	output reg countersNeedReading,
	output wire extendedDeferenceOn,
	output wire [3:0] extraDeferTimeCode,
	output wire twoWaySimultaneousOn,
	output wire bigFrameLimitSelect,
	output wire [7:0] lateCollisionCount
);

// Clock cycles per bit time at each link rate
localparam integer CYC_10M_WIDE = `MDLC_BIT_NS_10M / `MDLC_CLK_PERIOD_NS;
localparam integer CYC_100M_WIDE = `MDLC_BIT_NS_100M / `MDLC_CLK_PERIOD_NS;
localparam [3:0] CYC_PER_BIT_10M = CYC_10M_WIDE[3:0];
localparam [3:0] CYC_PER_BIT_100M = CYC_100M_WIDE[3:0];

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg [15:0] macSettings;
reg countingOn;
reg collSync1;
reg collSync2;
reg collSeen;
reg carrSync1;
reg carrSync2;
reg [3:0] bitCycle;
reg [9:0] attemptBits;
reg [12:0] rxBytes;
reg rxInFrame;
reg lateReadSinceSet;
reg otherReadSinceSet;
wire [3:0] cycPerBit;
wire bitTick;
wire collRise;
wire lateEvent;
wire lateCountEvent;
wire passedMid;
wire mediumBusy;
wire deferDone;
wire readLate;
wire readStatus;
wire writeSettings;
wire [12:0] sizeLimit;

function sel;
	input [2:0] win;
	input [3:0] addr;
	input [2:0] wantWin;
	input [3:0] wantAddr;
	begin
		sel = win == wantWin && addr == wantAddr;
	end
endfunction

// ----------------------------------------------------------------
// Register decode
// ----------------------------------------------------------------
assign readLate = ioRd && sel(ioWindow, ioAddr, `MDLC_WIN_LATE_COLL, `MDLC_OFF_LATE_COLL);
assign readStatus = ioRd && ioAddr == `MDLC_OFF_STATUS;
assign writeSettings = ioWr && sel(ioWindow, ioAddr, `MDLC_WIN_MAC_SET, `MDLC_OFF_MAC_SET);

// ----------------------------------------------------------------
// Settings register
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		// RULE6: all modes off
		macSettings <= `MDLC_MAC_SET_RESET;
	end else if (ce && writeSettings) begin
		macSettings <= ioWrData & `MDLC_MAC_SET_USED;
	end
end

assign extendedDeferenceOn = macSettings[`MDLC_BIT_EXT_DEFER];
assign extraDeferTimeCode = macSettings[`MDLC_FLD_DEFER_HI:`MDLC_FLD_DEFER_LO];
assign twoWaySimultaneousOn = macSettings[`MDLC_BIT_TWO_WAY];
assign bigFrameLimitSelect = macSettings[`MDLC_BIT_BIG_FRAME];

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		ioRdData <= 16'h0000;
	end else if (ce && ioRd) begin
		if (readLate) begin
			ioRdData <= {8'h00, lateCollisionCount};
		end else if (sel(ioWindow, ioAddr, `MDLC_WIN_MAC_SET, `MDLC_OFF_MAC_SET)) begin
			ioRdData <= macSettings;
		end else if (readStatus) begin
			// RULE16: status bit 7
			ioRdData <= {8'h00, countersNeedReading, 7'h00};
		end else begin
			ioRdData <= 16'h0000;
		end
	end
end

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		collSync1 <= 1'b0;
		collSync2 <= 1'b0;
		collSeen <= 1'b0;
		carrSync1 <= 1'b0;
		carrSync2 <= 1'b0;
	end else if (ce) begin
		collSync1 <= collisionPin;
		collSync2 <= collSync1;
		collSeen <= collSync2;
		carrSync1 <= carrierPin;
		carrSync2 <= carrSync1;
	end
end

assign collRise = collSync2 && !collSeen;

// ----------------------------------------------------------------
// Bit time tick
// ----------------------------------------------------------------
// RULE8: bit time scaled by rate
assign cycPerBit = linkIs100 ? CYC_PER_BIT_100M : CYC_PER_BIT_10M;

always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		bitCycle <= 4'h0;
	end else if (ce) begin
		if (bitTick) begin
			bitCycle <= 4'h0;
		end else begin
			bitCycle <= bitCycle + 4'h1;
		end
	end
end

assign bitTick = bitCycle >= cycPerBit - 4'h1;

// ----------------------------------------------------------------
// Late collision detection
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		attemptBits <= 10'd0;
	end else if (ce) begin
		if (txAttemptStart) begin
			attemptBits <= 10'd0;
		end else if (txActive && bitTick && attemptBits < `MDLC_SLOT_BITS) begin
			attemptBits <= attemptBits + 10'd1;
		end
	end
end

// RULE18: past first slot time
// RULE1: every attempt watched
assign lateEvent = collRise && txActive && attemptBits >= `MDLC_SLOT_BITS;

always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		countingOn <= 1'b0;
	end else if (ce && countingTurnOnCmd) begin
		countingOn <= 1'b1;
	end
end

// RULE5: only after enable command
assign lateCountEvent = lateEvent && countingOn;

mdlc_late_counter u_late_counter (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.ce(ce),
	.countEvent(lateCountEvent),
	.readClear(readLate),
	.count(lateCollisionCount),
	.passedMid(passedMid)
);

// ----------------------------------------------------------------
// Statistics update indication
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		countersNeedReading <= 1'b0;
		lateReadSinceSet <= 1'b0;
		otherReadSinceSet <= 1'b0;
	end else if (ce) begin
		if (passedMid) begin
			// RULE3: set wins over clear
			countersNeedReading <= 1'b1;
			lateReadSinceSet <= 1'b0;
			otherReadSinceSet <= 1'b0;
		end else if (countersNeedReading) begin
			// RULE16: clear after all read
			if ((lateReadSinceSet || readLate) && (otherReadSinceSet || otherStatsRead)) begin
				countersNeedReading <= 1'b0;
				lateReadSinceSet <= 1'b0;
				otherReadSinceSet <= 1'b0;
			end else begin
				lateReadSinceSet <= lateReadSinceSet || readLate;
				otherReadSinceSet <= otherReadSinceSet || otherStatsRead;
			end
		end
	end
end

// ----------------------------------------------------------------
// Deference
// ----------------------------------------------------------------
// RULE12: carrier masked in two-way mode
assign carrierToTx = carrSync2 && !twoWaySimultaneousOn;
assign lostCarrierCountOn = !twoWaySimultaneousOn;
// RULE11: no deferring to receive
assign mediumBusy = txActive || carrierToTx;

mdlc_defer_timer u_defer_timer (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.ce(ce),
	.bitTick(bitTick),
	.mediumBusy(mediumBusy),
	.txSuccess(txSuccess),
	.extendOn(extendedDeferenceOn),
	.extraCode(extraDeferTimeCode),
	.deferDone(deferDone)
);

assign txMayStart = deferDone;

// ----------------------------------------------------------------
// Oversized receive frame check
// ----------------------------------------------------------------
// RULE14: limit chosen by big frame bit
// RULE15: FCS excluded from length
assign sizeLimit = (bigFrameLimitSelect ? `MDLC_OVERSIZE_BIG : `MDLC_OVERSIZE_STD) + `MDLC_FCS_BYTES;

always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		rxBytes <= 13'd0;
		rxInFrame <= 1'b0;
		frameTooLongError <= 1'b0;
	end else if (ce) begin
		frameTooLongError <= 1'b0;
		if (rxFrameStart) begin
			rxBytes <= 13'd0;
			rxInFrame <= 1'b1;
		end else if (rxFrameEnd && rxInFrame) begin
			rxInFrame <= 1'b0;
			frameTooLongError <= rxBytes >= sizeLimit;
		end else if (rxInFrame && rxByteStrobe && rxBytes != 13'h1fff) begin
			rxBytes <= rxBytes + 13'd1;
		end
	end
end

endmodule

/* sim/mdlc_top_properties.sv */
`timescale 1ns/1ps
module mdlc_top_checker (
	input wire clk_sys,
	input wire resetn,
	input wire ce,
	input wire [2:0] ioWindow,
	input wire [3:0] ioAddr,
	input wire ioRd,
	input wire ioWr,
	input wire [15:0] ioWrData,
	input wire [15:0] ioRdData,
	input wire otherStatsRead,
	input wire countingTurnOnCmd,
	input wire linkIs100,
	input wire txAttemptStart,
	input wire txActive,
	input wire txSuccess,
	input wire collisionPin,
	input wire carrierPin,
	input wire rxFrameStart,
	input wire rxByteStrobe,
	input wire rxFrameEnd,
	input wire txMayStart,
	input wire carrierToTx,
	input wire lostCarrierCountOn,
	input wire frameTooLongError,
	input wire countersNeedReading,
	input wire extendedDeferenceOn,
	input wire [3:0] extraDeferTimeCode,
	input wire twoWaySimultaneousOn,
	input wire bigFrameLimitSelect,
	input wire [7:0] lateCollisionCount
);
	wire rdLate;
	reg seenOn;
	assign rdLate = ioRd && ioWindow == 3'h6 && ioAddr == 4'h4;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			seenOn <= 1'b0;
		else if (countingTurnOnCmd)
			seenOn <= 1'b1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	chk_settings_reset: assert property ($rose(resetn) |-> lateCollisionCount == 8'h00 &&
		{bigFrameLimitSelect, twoWaySimultaneousOn, extraDeferTimeCode, extendedDeferenceOn} == 7'h00)
		else $error("settings not cleared");
	chk_read_clears: assert property (ce && rdLate |=>
		ioRdData == {8'h00, $past(lateCollisionCount)} && lateCollisionCount <= 8'h01) else $error("read clear");
	chk_count_step: assert property (ce && !rdLate ##1 lateCollisionCount != $past(lateCollisionCount) |->
		lateCollisionCount == $past(lateCollisionCount) + 8'h01) else $error("count step");
	chk_mid_flag: assert property (lateCollisionCount == 8'h80 ##1 lateCollisionCount == 8'h81 |->
		##[0:1] countersNeedReading) else $error("midpoint flag");
	chk_no_count_off: assert property (!seenOn |=> lateCollisionCount == 8'h00) else $error("counted early");
	chk_two_way_mask: assert property (twoWaySimultaneousOn |->
		!carrierToTx && !lostCarrierCountOn) else $error("carrier not masked");
	chk_settings_write: assert property (ce && ioWr && ioWindow == 3'h3 && ioAddr == 4'h6 |=>
		{bigFrameLimitSelect, twoWaySimultaneousOn, extraDeferTimeCode, extendedDeferenceOn} == $past(ioWrData[6:0]))
		else $error("settings write");
	chk_status_bit: assert property (ce && ioRd && ioAddr == 4'he |=>
		ioRdData == {8'h00, $past(countersNeedReading), 7'h00}) else $error("status read");
	chk_too_long_pulse: assert property (frameTooLongError |-> $past(rxFrameEnd)) else $error("oversize timing");
	chk_gap_after_ok: assert property (ce && txSuccess |=> !txMayStart) else $error("no gap");
	cover property (lateCollisionCount == 8'h81);
	cover property (frameTooLongError);
	cover property (twoWaySimultaneousOn && carrierPin);
endmodule
bind mdlc_top mdlc_top_checker i_chk (.*);

/* sim/mdlc_medium_model.sv */
`timescale 1ns/1ps
module mdlc_medium_model (
	input wire clk_sys,
	input wire txAttemptStart,
	input wire txActive,
	input wire [15:0] collAt,
	input wire [7:0] nColl,
	input wire carrierReq,
	output reg collisionPin = 1'b0,
	output reg carrierPin = 1'b0
);
	reg [15:0] cyc = 16'h0000;
	wire [15:0] rel = cyc - collAt;
	always @(posedge clk_sys) begin
		cyc <= txAttemptStart ? 16'h0000 : cyc + 16'h0001;
		collisionPin <= txActive && cyc >= collAt && rel < 8 * nColl && !rel[2];
		carrierPin <= carrierReq || txActive;
	end
endmodule

/* sim/mdlc_top_tb_top.sv */
`timescale 1ns/1ps
module mdlc_top_tb_top;
	logic clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, ioRd = 1'b0, ioWr = 1'b0, linkIs100 = 1'b1;
	logic otherStatsRead = 1'b0, countingTurnOnCmd = 1'b0, txAttemptStart = 1'b0, txActive = 1'b0;
	logic txSuccess = 1'b0, carrierReq = 1'b0, rxFrameStart = 1'b0, rxByteStrobe = 1'b0, rxFrameEnd = 1'b0;
	logic [2:0] ioWindow = 3'h0;
	logic [3:0] ioAddr = 4'h0;
	logic [15:0] ioWrData = 16'h0000, collAt = 16'h0000;
	logic [7:0] nColl = 8'h00;
	wire collisionPin, carrierPin, txMayStart, carrierToTx, lostCarrierCountOn, frameTooLongError;
	wire countersNeedReading, extendedDeferenceOn, twoWaySimultaneousOn, bigFrameLimitSelect;
	wire [3:0] extraDeferTimeCode;
	wire [7:0] lateCollisionCount;
	wire [15:0] ioRdData;
	int fail_count = 0;
	int checks_done = 0;
	always #5 clk_sys = ~clk_sys;
	mdlc_top i_dut (.*);
	mdlc_medium_model i_medium (.*);
	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task chk(input [15:0] got, input [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [2:0] w, input [3:0] a, input [15:0] d);
		@(negedge clk_sys);
		ioWindow = w;
		ioAddr = a;
		ioWrData = d;
		ioWr = 1'b1;
		@(negedge clk_sys) ioWr = 1'b0;
	endtask
	task rdc(input [2:0] w, input [3:0] a, input [15:0] e);
		@(negedge clk_sys);
		ioWindow = w;
		ioAddr = a;
		ioRd = 1'b1;
		@(negedge clk_sys) ioRd = 1'b0;
		chk(ioRdData, e);
	endtask
	task att(input [15:0] at, input [7:0] n);
		@(negedge clk_sys);
		collAt = at;
		nColl = n;
		txAttemptStart = 1'b1;
		txActive = 1'b1;
		@(negedge clk_sys) txAttemptStart = 1'b0;
		repeat (at + 8 * n + 20) @(negedge clk_sys);
		txActive = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask
	task dly(input ext, input [3:0] c, input fast, input int e, input int tol);
		int n;
		wr(3'h3, 4'h6, {11'h000, c, ext});
		linkIs100 = fast;
		@(negedge clk_sys) txSuccess = 1'b1;
		@(negedge clk_sys) txSuccess = 1'b0;
		n = 1;
		while (!txMayStart && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		chk(n >= e - tol && n <= e + tol, 16'h0001);
	endtask
	task rxf(input big, input int nb, input e);
		wr(3'h3, 4'h6, {9'h000, big, 6'h00});
		@(negedge clk_sys) rxFrameStart = 1'b1;
		@(negedge clk_sys) rxFrameStart = 1'b0;
		rxByteStrobe = 1'b1;
		repeat (nb) @(negedge clk_sys);
		rxByteStrobe = 1'b0;
		rxFrameEnd = 1'b1;
		@(negedge clk_sys) rxFrameEnd = 1'b0;
		chk(frameTooLongError, e);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rdc(3'h3, 4'h6, 16'h0000);
		wr(3'h3, 4'h6, 16'hffff);
		rdc(3'h3, 4'h6, 16'h007f);
		chk({bigFrameLimitSelect, twoWaySimultaneousOn, extraDeferTimeCode, extendedDeferenceOn}, 16'h007f);
		wr(3'h6, 4'h4, 16'h00aa);
		rdc(3'h6, 4'h4, 16'h0000);
		rdc(3'h2, 4'h0, 16'h0000);
		ce = 1'b0;
		wr(3'h3, 4'h6, 16'h0001);
		ce = 1'b1;
		rdc(3'h3, 4'h6, 16'h007f);
		wr(3'h3, 4'h6, 16'h0000);
	endtask
	task t_count;
		att(16'd600, 8'd2);
		rdc(3'h6, 4'h4, 16'h0000);
		@(negedge clk_sys) countingTurnOnCmd = 1'b1;
		@(negedge clk_sys) countingTurnOnCmd = 1'b0;
		att(16'd100, 8'd2);
		rdc(3'h6, 4'h4, 16'h0000);
		att(16'd600, 8'd3);
		rdc(3'h6, 4'h4, 16'h0003);
		rdc(3'h6, 4'h4, 16'h0000);
		// Clearing read lands on the edge that counts the collision
		fork
			att(16'd600, 8'd1);
			begin
				@(negedge clk_sys);
				while (!collisionPin) @(negedge clk_sys);
				@(negedge clk_sys);
				rdc(3'h6, 4'h4, 16'h0000);
			end
		join
		chk(lateCollisionCount, 16'h0001);
		rdc(3'h6, 4'h4, 16'h0001);
	endtask
	task t_wrap;
		att(16'd600, 8'd128);
		rdc(3'h0, 4'he, 16'h0000);
		att(16'd600, 8'd1);
		rdc(3'h1, 4'he, 16'h0080);
		att(16'd600, 8'd127);
		chk(lateCollisionCount, 16'h0000);
		rdc(3'h6, 4'h4, 16'h0000);
		rdc(3'h6, 4'he, 16'h0080);
		@(negedge clk_sys) otherStatsRead = 1'b1;
		@(negedge clk_sys) otherStatsRead = 1'b0;
		rdc(3'h6, 4'he, 16'h0000);
	endtask
	task t_defer;
		for (int c = 0; c < 16; c++)
			dly(1'b1, c[3:0], 1'b1, 96 + ((c >= 2) ? (c - 1) * 32 : 0), 3);
		dly(1'b0, 4'hf, 1'b1, 96, 3);
		dly(1'b0, 4'h0, 1'b0, 960, 12);
		linkIs100 = 1'b1;
	endtask
	task t_duplex;
		carrierReq = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk({carrierToTx, lostCarrierCountOn}, 16'h0003);
		wr(3'h3, 4'h6, 16'h0020);
		repeat (200) @(negedge clk_sys);
		chk({carrierToTx, lostCarrierCountOn}, 16'h0000);
		chk(txMayStart, 16'h0001);
		carrierReq = 1'b0;
		wr(3'h3, 4'h6, 16'h0000);
	endtask
	task t_size;
		rxf(1'b0, 1518, 1'b0);
		rxf(1'b0, 1519, 1'b1);
		rxf(1'b1, 4494, 1'b0);
		rxf(1'b1, 4495, 1'b1);
	endtask
	task finish_test;
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		resetn = 1'b1;
		t_regs;
		t_count;
		t_wrap;
		t_defer;
		t_duplex;
		t_size;
		finish_test;
	end
	initial begin
		#500000;
		fail_count++;
		finish_test;
	end
endmodule
